// ===== logic/ptm_pkg.sv
package ptm_pkg;

	// Operating mode field.
	typedef enum logic [1:0] {
		PTM_MODE_CMP   = 2'b00,
		PTM_MODE_CAP   = 2'b01,
		PTM_MODE_PWM   = 2'b10,
		PTM_MODE_TIMER = 2'b11
	} ptm_mode_t;

	// Counter clock source field.
	typedef enum logic [2:0] {
		PTM_CK_SYS4  = 3'b000,
		PTM_CK_SYS   = 3'b001,
		PTM_CK_H16   = 3'b010,
		PTM_CK_H64   = 3'b011,
		PTM_CK_SUB   = 3'b100,
		PTM_CK_NONE  = 3'b101,
		PTM_CK_PINR  = 3'b110,
		PTM_CK_PINF  = 3'b111
	} ptm_clk_t;

endpackage

// ===== logic/ptm_regs.svh
`ifndef PTM_REGS_SVH
`define PTM_REGS_SVH

// Register byte offsets on the APB port.
`define PTM_OFF_CTRL0     8'h00
`define PTM_OFF_CTRL1     8'h04
`define PTM_OFF_CNT_LO    8'h08
`define PTM_OFF_CNT_HI    8'h0c
`define PTM_OFF_CMPA_LO   8'h10
`define PTM_OFF_CMPA_HI   8'h14
`define PTM_OFF_CMPP_LO   8'h18
`define PTM_OFF_CMPP_HI   8'h1c
`define PTM_OFF_FLAGS     8'h20

// Control register zero fields.
`define PTM_C0_PAUSE      7
`define PTM_C0_CLK_MSB    6
`define PTM_C0_CLK_LSB    4
`define PTM_C0_ON         3

// Control register one fields.
`define PTM_C1_MODE_MSB   7
`define PTM_C1_MODE_LSB   6
`define PTM_C1_FUNC_MSB   5
`define PTM_C1_FUNC_LSB   4
`define PTM_C1_INIT       3
`define PTM_C1_INV        2
`define PTM_C1_CAPTS      1
`define PTM_C1_CCLR       0

// Flag register fields.
`define PTM_FL_A          0
`define PTM_FL_P          1

// Reset values.
`define PTM_RST_BYTE      8'h00
`define PTM_RST_CNT       10'h000

// Prescaler: system clock divides of 4, 16 and 64.
`define PTM_DIV4_MASK     6'h03
`define PTM_DIV16_MASK    6'h0f
`define PTM_DIV64_MASK    6'h3f

`endif

// ===== logic/ptm_timer.sv
`timescale 1ns/1ps
`include "ptm_regs.svh"

module ptm_timer
(
	// Clock and reset.
	input  wire logic        i_ref_clk,
	input  wire logic        i_nrst,
	// APB slave.
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	// Clock pins from outside the clock domain.
	input  wire logic        i_external_clock_pin,
	input  wire logic        i_sub_clk,
	// Timer output pins and status.
	output logic             o_timer_pin_zero,
	output logic             o_timer_pin_one,
	output logic             o_timer_pin_oe,
	output logic             o_match_a_flag,
	output logic             o_match_p_flag
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]        ctrl0_ff;
	logic [7:0]        ctrl1_ff;
	logic [9:0]        cnt_ff;
	logic [9:0]        nxt_cnt;
	logic [9:0]        cmpa_ff;
	logic [9:0]        cmpp_ff;
	logic              flag_a_ff;
	logic              flag_p_ff;
	logic              on_prev_ff;
	logic              pin_ff;
	logic              nxt_pin;
	logic              pin_out_ff;
	logic              pin_oe_ff;
	logic [5:0]        pre_ff;
	logic              pready_ff;
	logic [31:0]       prdata_ff;
	logic              pslverr_ff;
	logic [1:0]        sy1_ff;
	logic [1:0]        sy2_ff;
	logic [1:0]        sy3_ff;
	logic [1:0]        lvl_ff;
	logic [1:0]        rise;
	logic [1:0]        fall;

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	wire               pause    = ctrl0_ff[`PTM_C0_PAUSE];
	wire               cnt_on   = ctrl0_ff[`PTM_C0_ON];
	wire [2:0]         clk_sel  = ctrl0_ff[`PTM_C0_CLK_MSB:`PTM_C0_CLK_LSB];
	wire [1:0]         mode     = ctrl1_ff[`PTM_C1_MODE_MSB:`PTM_C1_MODE_LSB];
	wire [1:0]         func     = ctrl1_ff[`PTM_C1_FUNC_MSB:`PTM_C1_FUNC_LSB];
	wire               init_lvl = ctrl1_ff[`PTM_C1_INIT];
	wire               invert   = ctrl1_ff[`PTM_C1_INV];
	wire               clr_sel  = ctrl1_ff[`PTM_C1_CCLR];

	wire               is_pwm   = (mode == ptm_pkg::PTM_MODE_PWM);
	wire               is_cmp   = (mode == ptm_pkg::PTM_MODE_CMP);
	wire               is_timer = (mode == ptm_pkg::PTM_MODE_TIMER);
	wire               on_rise  = cnt_on & ~on_prev_ff;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Bit 0 is the external clock pin, bit 1 the sub clock. A change is
	// accepted only when stages two and three agree, which filters a
	// one-cycle glitch at the cost of one cycle of latency.
	wire [1:0]         pin_raw  = {i_sub_clk, i_external_clock_pin};

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_sync
			always_ff @(posedge i_ref_clk or negedge i_nrst)
			begin
				if (!i_nrst)
				begin
					sy1_ff[g] <= 1'b0;
					sy2_ff[g] <= 1'b0;
					sy3_ff[g] <= 1'b0;
					lvl_ff[g] <= 1'b0;
				end
				else
				begin
					sy1_ff[g] <= pin_raw[g];
					sy2_ff[g] <= sy1_ff[g];
					sy3_ff[g] <= sy2_ff[g];
					if (sy2_ff[g] == sy3_ff[g])
						lvl_ff[g] <= sy3_ff[g];
				end
			end
			assign rise[g] = (sy2_ff[g] == sy3_ff[g]) & sy3_ff[g] & ~lvl_ff[g];
			assign fall[g] = (sy2_ff[g] == sy3_ff[g]) & ~sy3_ff[g] & lvl_ff[g];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Counter clock select
	// ----------------------------------------------------------------
	// The high-speed internal clock is taken as the system clock, so
	// the divide-by settings all come from one free-running prescaler.
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			pre_ff <= 6'h00;
		else
			pre_ff <= pre_ff + 6'h01;
	end

	logic              tick;
	always_comb
	begin
		unique case (ptm_pkg::ptm_clk_t'(clk_sel))
			ptm_pkg::PTM_CK_SYS4: tick = ((pre_ff & `PTM_DIV4_MASK) == 6'h00);
			ptm_pkg::PTM_CK_SYS:  tick = 1'b1;
			ptm_pkg::PTM_CK_H16:  tick = ((pre_ff & `PTM_DIV16_MASK) == 6'h00);
			ptm_pkg::PTM_CK_H64:  tick = ((pre_ff & `PTM_DIV64_MASK) == 6'h00);
			ptm_pkg::PTM_CK_SUB:  tick = rise[1];
			ptm_pkg::PTM_CK_NONE: tick = 1'b0; // Reserved code stops counting.
			ptm_pkg::PTM_CK_PINR: tick = rise[0];
			ptm_pkg::PTM_CK_PINF: tick = fall[0];
		endcase
	end

	// ----------------------------------------------------------------
	// Comparators
	// ----------------------------------------------------------------
	// Matches look at the value the counter is about to take, so a
	// compare P value of N gives a period of N counts, and zero wraps
	// at 1023 to give the full 1024 count overflow period.
	wire               run      = tick & cnt_on & ~pause & ~on_rise;
	wire [9:0]         cnt_inc  = cnt_ff + 10'h001;
	wire               hit_a    = run & (cnt_inc == cmpa_ff);
	wire               hit_p    = run & (cnt_inc == cmpp_ff);
	wire               clr_by_a = ~is_pwm & clr_sel;

	// Clearing source and flag enables per mode.
	wire               cnt_clr  = clr_by_a ? hit_a : hit_p;
	wire               set_a    = hit_a;
	wire               set_p    = hit_p & ~clr_by_a;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (on_rise)
			nxt_cnt = `PTM_RST_CNT;
		else if (cnt_clr)
			nxt_cnt = `PTM_RST_CNT;
		else if (run)
			nxt_cnt = cnt_inc;
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cnt_ff     <= `PTM_RST_CNT;
			on_prev_ff <= 1'b0;
		end
		else
		begin
			cnt_ff     <= nxt_cnt;
			on_prev_ff <= cnt_on;
		end
	end

	// ----------------------------------------------------------------
	// Compare mode pin state
	// ----------------------------------------------------------------
	// After the start level is loaded, the pin only moves on an A match; P matches never reach it.
	always_comb
	begin
		nxt_pin = pin_ff;
		if (on_rise)
			nxt_pin = init_lvl;
		else if (set_a)
		begin
			unique case (func)
				2'b00: nxt_pin = pin_ff;
				2'b01: nxt_pin = 1'b0;
				2'b10: nxt_pin = 1'b1;
				2'b11: nxt_pin = ~pin_ff;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			pin_ff <= 1'b0;
		else
			pin_ff <= nxt_pin;
	end

	// ----------------------------------------------------------------
	// PWM waveform
	// ----------------------------------------------------------------
	// Active for the first compare A counts of each period. A duty at or
	// above the period keeps the comparison true for every count.
	wire [10:0]        period   = (cmpp_ff == 10'h000) ? 11'h400 : {1'b0, cmpp_ff};
	wire               duty_all = ({1'b0, cmpa_ff} >= period);
	wire               pwm_act  = duty_all | (cnt_ff < cmpa_ff);

	logic              pwm_lvl;
	always_comb
	begin
		unique case (func)
			2'b00: pwm_lvl = ~init_lvl;
			2'b01: pwm_lvl = init_lvl;
			2'b10: pwm_lvl = pwm_act ? init_lvl : ~init_lvl;
			2'b11: pwm_lvl = ~init_lvl; // Single pulse is not built here.
		endcase
	end

	// Output selection; timer and capture modes release the pin.
	wire               pin_val  = (is_pwm ? pwm_lvl : pin_ff) ^ invert;
	wire               pin_en   = (is_pwm | is_cmp) & ~is_timer;

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			pin_out_ff <= 1'b0;
			pin_oe_ff  <= 1'b0;
		end
		else
		begin
			pin_out_ff <= pin_val;
			pin_oe_ff  <= pin_en;
		end
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// One wait state: data is captured in the first access cycle so that
	// read data and ready come straight from flip-flops.
	wire               acc      = i_psel & i_penable;
	wire               take     = acc & pready_ff;
	wire               wr       = take & i_pwrite & i_pstrb[0];
	wire [7:0]         wd       = i_pwdata[7:0];

	wire               sel_c0   = (i_paddr == `PTM_OFF_CTRL0);
	wire               sel_c1   = (i_paddr == `PTM_OFF_CTRL1);
	wire               sel_dl   = (i_paddr == `PTM_OFF_CNT_LO);
	wire               sel_dh   = (i_paddr == `PTM_OFF_CNT_HI);
	wire               sel_al   = (i_paddr == `PTM_OFF_CMPA_LO);
	wire               sel_ah   = (i_paddr == `PTM_OFF_CMPA_HI);
	wire               sel_pl   = (i_paddr == `PTM_OFF_CMPP_LO);
	wire               sel_ph   = (i_paddr == `PTM_OFF_CMPP_HI);
	wire               sel_fl   = (i_paddr == `PTM_OFF_FLAGS);
	wire               mapped   = sel_c0 | sel_c1 | sel_dl | sel_dh | sel_al |
	                              sel_ah | sel_pl | sel_ph | sel_fl;

	// Read mux; high bytes carry only two live bits.
	wire [7:0]         rd_byte  =
		sel_c0 ? {ctrl0_ff[7:3], 3'b000} :
		sel_c1 ? ctrl1_ff :
		sel_dl ? cnt_ff[7:0] :
		sel_dh ? {6'h00, cnt_ff[9:8]} :
		sel_al ? cmpa_ff[7:0] :
		sel_ah ? {6'h00, cmpa_ff[9:8]} :
		sel_pl ? cmpp_ff[7:0] :
		sel_ph ? {6'h00, cmpp_ff[9:8]} :
		sel_fl ? {6'h00, flag_p_ff, flag_a_ff} :
		8'h00;

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff  <= acc & ~pready_ff;
			prdata_ff  <= (acc & ~pready_ff & ~i_pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
			pslverr_ff <= acc & ~pready_ff & ~mapped;
		end
	end

	// ----------------------------------------------------------------
	// Control and compare registers
	// ----------------------------------------------------------------
	// Software is expected to keep compare A nonzero in compare mode;
	// a zero there simply never matches until the counter wraps.
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ctrl0_ff <= `PTM_RST_BYTE;
			ctrl1_ff <= `PTM_RST_BYTE;
			cmpa_ff  <= `PTM_RST_CNT;
			cmpp_ff  <= `PTM_RST_CNT;
		end
		else
		begin
			if (wr & sel_c0)
				ctrl0_ff <= {wd[7:3], 3'b000};
			if (wr & sel_c1)
				ctrl1_ff <= wd;
			if (wr & sel_al)
				cmpa_ff[7:0] <= wd;
			if (wr & sel_ah)
				cmpa_ff[9:8] <= wd[1:0];
			if (wr & sel_pl)
				cmpp_ff[7:0] <= wd;
			if (wr & sel_ph)
				cmpp_ff[9:8] <= wd[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Match flags
	// ----------------------------------------------------------------
	// Write one to clear. A match in the same cycle as the clear wins so
	// that no event is lost.
	wire               clr_a    = wr & sel_fl & wd[`PTM_FL_A];
	wire               clr_p    = wr & sel_fl & wd[`PTM_FL_P];

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			flag_a_ff <= 1'b0;
			flag_p_ff <= 1'b0;
		end
		else
		begin
			flag_a_ff <= set_a | (flag_a_ff & ~clr_a);
			flag_p_ff <= set_p | (flag_p_ff & ~clr_p);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_pready         = pready_ff;
	assign o_prdata         = prdata_ff;
	assign o_pslverr        = pslverr_ff;
	assign o_timer_pin_zero = pin_out_ff;
	assign o_timer_pin_one  = pin_out_ff;
	assign o_timer_pin_oe   = pin_oe_ff;
	assign o_match_a_flag   = flag_a_ff;
	assign o_match_p_flag   = flag_p_ff;

endmodule

// ===== test/periodic_timer_compare_pwm_bench.sv
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench for the timer.
// ----------------------------------------
module periodic_timer_compare_pwm_bench;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [31:0] e;} ptm_row_t;
	typedef struct {logic [7:0] c; logic [7:0] a; logic [7:0] p; int n; int e;} ptm_pwm_t;
	logic        i_ref_clk = 1'b0;
	logic        i_nrst = 1'b0;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [7:0]  i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0;
	logic [3:0]  i_pstrb = 4'hf;
	logic        i_external_clock_pin = 1'b0;
	logic        i_sub_clk = 1'b0;
	logic        o_pready, o_pslverr, o_timer_pin_zero, o_timer_pin_one, o_timer_pin_oe;
	logic        o_match_a_flag, o_match_p_flag, rerr;
	logic [31:0] o_prdata, rdat;
	int          bad_count = 0;
	int          n_compared = 0;
	int          hi;
	ptm_row_t    rows[8] = '{'{8'h10, 8'ha5, 32'ha5}, '{8'h14, 8'hff, 32'h3}, '{8'h18, 8'h5a, 32'h5a},
		'{8'h1c, 8'hfe, 32'h2}, '{8'h08, 8'h77, 32'h0}, '{8'h0c, 8'hff, 32'h0}, '{8'h04, 8'hff, 32'hff},
		'{8'h00, 8'hf7, 32'hf0}};
	ptm_pwm_t    pwm[8] = '{'{8'ha8, 3, 8, 16, 6}, '{8'hac, 3, 8, 16, 10}, '{8'ha0, 3, 8, 16, 10},
		'{8'ha8, 9, 8, 16, 16}, '{8'h88, 3, 8, 16, 0}, '{8'h98, 3, 8, 16, 16}, '{8'ha9, 3, 8, 16, 6},
		'{8'ha8, 3, 0, 1024, 3}};

	ptm_timer uut (.i_ref_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
		.o_pready, .o_prdata, .o_pslverr, .i_external_clock_pin, .i_sub_clk, .o_timer_pin_zero,
		.o_timer_pin_one, .o_timer_pin_oe, .o_match_a_flag, .o_match_p_flag);

	// Free-running 20 MHz clock.
	always #25 i_ref_clk = ~i_ref_clk;

	// ----------------------------------------
	// Tasks.
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One transfer: the request stands until pready is sampled high at a rising edge.
	// There is no local limit, so a missing answer is caught by the watchdog.
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= {24'h0, d};
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		do
			@(posedge i_ref_clk);
		while (o_pready !== 1'b1);
		rdat = o_prdata;
		rerr = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rdat, exp);
	endtask

	// Stops the counter, loads settings, clears flags and restarts on the system clock.
	// Callers always pass a nonzero compare A value.
	task automatic go(input logic [7:0] c, input logic [7:0] a, input logic [7:0] p, input int n);
		apb(1'b1, 8'h00, 8'h10);
		apb(1'b1, 8'h10, a);
		apb(1'b1, 8'h18, p);
		apb(1'b1, 8'h04, c);
		apb(1'b1, 8'h20, 8'h03);
		apb(1'b1, 8'h00, 8'h18);
		repeat (n) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Watchdog, well beyond the few thousand cycles the run needs.
	initial
	begin
		repeat (30000) @(posedge i_ref_clk);
		bad_count++;
		test_done();
	end

	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial
	begin
		repeat (12) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		for (int a = 0; a <= 32; a += 4)
			rd(a[7:0], 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		apb(1'b0, 8'h24, 8'h00);
		chk(rerr, 1'b1);
		@(posedge i_ref_clk);
		i_pstrb <= 4'he;
		apb(1'b1, 8'h10, 8'h11);
		i_pstrb <= 4'hf;
		rd(8'h10, 32'ha5);
		apb(1'b1, 8'h14, 8'h00);
		apb(1'b1, 8'h1c, 8'h00);
		// Every compare function from both initial levels; one match in the window.
		for (int i = 0; i < 8; i++)
		begin
			go({2'b00, i[1:0], i[2], 3'b000}, 3, 0, 20);
			hi = (i[1:0] == 0) ? i[2] : (i[1:0] == 3) ? !i[2] : i[1];
			chk(o_timer_pin_zero, hi);
			chk(o_timer_pin_one, hi);
			chk(o_match_a_flag, 1'b1);
		end
		go(8'h00, 3, 6, 40);
		chk({o_match_a_flag, o_match_p_flag}, 2'b11);
		apb(1'b1, 8'h00, 8'h10);
		apb(1'b0, 8'h08, 8'h00);
		chk(rdat < 6, 1'b1);
		rd(8'h08, rdat);
		go(8'h01, 5, 2, 40);
		chk({o_match_a_flag, o_match_p_flag}, 2'b10);
		apb(1'b1, 8'h00, 8'h10);
		apb(1'b0, 8'h08, 8'h00);
		chk(rdat < 5, 1'b1);
		go(8'hc0, 3, 6, 40);
		chk({o_timer_pin_oe, o_match_a_flag, o_match_p_flag}, 3'b011);
		// PWM rows: high cycles of pin zero counted over whole periods.
		for (int i = 0; i < 8; i++)
		begin
			go(pwm[i].c, pwm[i].a, pwm[i].p, 4);
			hi = 0;
			repeat (pwm[i].n)
			begin
				@(negedge i_ref_clk);
				hi += (o_timer_pin_zero === 1'b1);
			end
			chk(hi, pwm[i].e);
			chk(o_timer_pin_oe, 1'b1);
			chk(o_match_p_flag, 1'b1);
			chk(o_match_a_flag, pwm[i].p == 0 || pwm[i].a < pwm[i].p);
		end
		// Sub clock and both pin edges, five pulses each.
		go(8'hc0, 3, 0, 1);
		for (int k = 4; k < 8; k += (k == 4) ? 2 : 1)
		begin
			apb(1'b1, 8'h00, 8'h10);
			apb(1'b1, 8'h00, {1'b0, k[2:0], 4'h8});
			repeat (5)
			begin
				i_external_clock_pin <= 1'b1;
				i_sub_clk <= 1'b1;
				repeat (4) @(posedge i_ref_clk);
				i_external_clock_pin <= 1'b0;
				i_sub_clk <= 1'b0;
				repeat (4) @(posedge i_ref_clk);
			end
			repeat (8) @(posedge i_ref_clk);
			apb(1'b1, 8'h00, 8'h10);
			rd(8'h08, 32'h5);
		end
		// Divided system clocks: about ten ticks each; the prescaler phase allows one more or less.
		for (int j = 0; j < 3; j++)
		begin
			hi = (j == 0) ? 4 : (j == 1) ? 16 : 64;
			apb(1'b1, 8'h00, 8'h10);
			apb(1'b1, 8'h00, (j == 0) ? 8'h08 : (j == 1) ? 8'h28 : 8'h38);
			repeat (10 * hi) @(posedge i_ref_clk);
			apb(1'b1, 8'h00, 8'h10);
			apb(1'b0, 8'h08, 8'h00);
			chk(rdat >= 9 && rdat <= 11, 1'b1);
		end
		apb(1'b1, 8'h00, 8'h58);
		repeat (20) @(posedge i_ref_clk);
		rd(8'h08, 32'h0);
		apb(1'b1, 8'h00, 8'h10);
		apb(1'b1, 8'h00, 8'h98);
		repeat (20) @(posedge i_ref_clk);
		rd(8'h08, 32'h0);
		i_nrst <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		rd(8'h10, 32'h0);
		test_done();
	end
endmodule

// ===== test/ptm_timer_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the timer.
// ----------------------------------------
module ptm_timer_monitor
(
	// Clock and reset.
	input wire logic        i_ref_clk,
	input wire logic        i_nrst,
	// Bus.
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0]  i_pstrb,
	input wire logic        o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pslverr,
	// Pins and flags.
	input wire logic        o_timer_pin_zero,
	input wire logic        o_timer_pin_oe,
	input wire logic        o_match_a_flag,
	input wire logic        o_match_p_flag
);
	logic       wr_ok;
	logic [7:0] c1_ff;
	logic       on_ff;

	// Shadow copies of control bits, since the checker cannot see inside.
	assign wr_ok = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0];
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			c1_ff <= 8'h00;
			on_ff <= 1'b0;
		end
		else if (wr_ok && i_paddr == 8'h04)
			c1_ff <= i_pwdata[7:0];
		else if (wr_ok && i_paddr == 8'h00)
			on_ff <= i_pwdata[3];
	end

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	// Bus answers and unused high bits.
	property p_rdy; i_psel && i_penable && !o_pready |=> o_pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing");
	property p_err; o_pready && i_paddr[1:0] == 2'b00 |-> o_pslverr == (i_paddr > 8'h20); endproperty
	a_err: assert property (p_err) else $error("wrong error answer");
	property p_hi; o_pready && !i_pwrite && i_paddr inside {8'h0c, 8'h14, 8'h1c} |-> o_prdata[31:2] == 30'h0; endproperty
	a_hi: assert property (p_hi) else $error("unused bits set");

	// Flags and pin use per mode.
	property p_nop; (c1_ff[0] && c1_ff[7] == c1_ff[6]) [*3] |-> !$rose(o_match_p_flag); endproperty
	a_nop: assert property (p_nop) else $error("P flag with A clear");
	property p_nooe; (c1_ff[7:6] == 2'b11) [*3] |-> !o_timer_pin_oe; endproperty
	a_nooe: assert property (p_nooe) else $error("pin driven in timer mode");
	property p_oe; (c1_ff[7:6] == 2'b10) [*3] |-> o_timer_pin_oe; endproperty
	a_oe: assert property (p_oe) else $error("pin not driven in PWM");

	// Pin level on start and on match. Holds for any compare A value.
	property p_init; wr_ok && i_paddr == 8'h00 && i_pwdata[3] && !on_ff && c1_ff[7:6] == 2'b00 && !c1_ff[2]
		|-> ##[1:3] o_timer_pin_zero == c1_ff[3]; endproperty
	a_init: assert property (p_init) else $error("initial level not set");
	property p_high; $rose(o_match_a_flag) && c1_ff[7:4] == 4'b0010 && !c1_ff[2] |-> ##[1:2] o_timer_pin_zero;
	endproperty
	a_high: assert property (p_high) else $error("pin not set on match");
endmodule

bind ptm_timer ptm_timer_monitor u_mon (.i_ref_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr, .o_timer_pin_zero, .o_timer_pin_oe,
	.o_match_a_flag, .o_match_p_flag);
